// File: design/odt_ctrl.sv
/*
 * synchronous and dynamic on-die termination selection of the dram.
 * assumes commands from the decoder on core_clk and the odt pin from outside.
 */
// Our own choices: the register addresses and the address-and-strobe port.
// Function
// - synchronous timing while dll locked
// - same timing in active, idle, power down
// - nominal on/off at wl-2 with 1tck
// - 2tck preamble latencies are wl-3
// - al and pl enter every latency
// - read turns termination off cl+al+pl-2/3
// - chop4 read back to park or nom after +4/+5
// - bl8 read back to park or nom after +6/+7
// - no termination while driving read data
// - dynamic mode when either wr bit set and the dll locked
// - nom, park, wr codes from registers
// - park while odt low, nom while high
// - write termination at wl-2 or wl-3
// - burst mode picks chop4 or bl8 end
// - chop4 write lasts 4,7,5,8 clocks
// - bl8 write lasts 6,7,7,8 clocks
`timescale 1ns/1ns
module odt_ctrl #(
    parameter int MAX_LAT = 64                             // longest latency held
) (
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    input  wire logic              ce,
    input  wire logic              odt_pin,                // asynchronous pin
    input  wire odt_pkg::dram_cmd_t cmd,
    input  wire logic [3:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_we,
    input  wire logic              reg_re,
    output      logic [31:0]       reg_rdata,
    output      odt_pkg::rtt_sel_t rtt_sel,
    output      logic [2:0]        rtt_value
);
    import odt_pkg::*;

    // ==========================================================
    // elaboration checks: 7-bit latencies and the tap clamp need this depth range
    if (MAX_LAT < 8 || MAX_LAT > 127) begin : g_bad_depth
        $error("MAX_LAT out of range");
    end

    // ==========================================================
    // helpers
    // latency from base, al and pl less the preamble trim
    // seven bits cannot hold the largest sum of 141, so a sum above 127 wraps before the trim
    function automatic logic [6:0] lat_of(input logic [5:0] base, input logic [5:0] al,
                                          input logic [3:0] pl, input logic pre2);
        logic [6:0] sum;
        sum = {1'b0, base} + {1'b0, al} + {3'b000, pl};
        lat_of = sum - (pre2 ? TRIM_2TCK : TRIM_1TCK);
    endfunction : lat_of

    // history tap for an effect lat clocks after the sampling edge
    function automatic int tap(input logic [6:0] lat, input int lag);
        int t;
        t = int'(lat) - 1 - lag;
        if (t < 0) begin
            t = 0;                                         // too short: earliest tap
        end else if (t > MAX_LAT - 1) begin
            t = MAX_LAT - 1;
        end
        tap = t;
    endfunction : tap

    // write termination length by burst, preamble and crc
    function automatic logic [3:0] wr_len(input logic bc4, input logic pre2,
                                          input logic crc);
        logic [3:0] n;
        n = 4'h0;
        case ({bc4, pre2, crc})
            3'b100:  n = WR4_1T;
            3'b101:  n = WR4_1T_CRC;
            3'b110:  n = WR4_2T;
            3'b111:  n = WR4_2T_CRC;
            3'b000:  n = WR8_1T;
            3'b001:  n = WR8_1T_CRC;
            3'b010:  n = WR8_2T;
            default: n = WR8_2T_CRC;
        endcase
        wr_len = n;
    endfunction : wr_len

    // ==========================================================
    // registers and synchroniser state
    lat_reg_t             lat_q;                           // latency settings
    mode_reg_t            mode_q;                          // mode settings
    rtt_reg_t             rtt_q;                           // termination codes
    logic                 odt_s1;                          // first sync stage
    logic                 odt_s2;                          // second sync stage
    logic [MAX_LAT-1:0]   odt_hist;                        // odt level history
    logic [MAX_LAT-1:0]   wr_hist;                         // write command history
    logic [MAX_LAT-1:0]   wbc4_hist;                       // chop flag of writes
    logic [MAX_LAT-1:0]   rd_hist;                         // read command history
    logic [MAX_LAT-1:0]   rbc4_hist;                       // chop flag of reads
    logic [3:0]           wrc;                             // write window left
    logic [3:0]           rdc;                             // read quiet left
    logic                 nom_q;                           // nominal requested

    logic [31:0]          next_lat, next_mode, next_rtt, next_rdata;
    logic [MAX_LAT-1:0]   next_odt_hist, next_wr_hist, next_wbc4_hist;
    logic [MAX_LAT-1:0]   next_rd_hist, next_rbc4_hist;
    logic [3:0]           next_wrc, next_rdc;
    logic                 next_nom;
    rtt_sel_t             next_sel;
    logic [2:0]           next_value;

    // decoded settings
    logic [6:0]           dodt;                            // direct odt latency
    logic [6:0]           roff;                            // read turn off latency
    logic                 dyn;                             // dynamic mode on
    logic                 cmd_bc4;                         // chop for this command
    logic                 wr_arrive, rd_arrive;            // window starts now
    logic [3:0]           wlen, rlen;

    // ==========================================================
    // latency decode
    always_comb begin
        // write and read latency based, al and pl included, trimmed by preamble
        dodt = lat_of(lat_q.cwl, lat_q.al, lat_q.pl, mode_q.pre2);
        roff = lat_of(lat_q.cl, lat_q.al, lat_q.pl, mode_q.pre2);
        // either wr bit set enables switching; unsupported without the dll
        dyn = (rtt_q.wr != 2'b00) && mode_q.dll_locked;
        // fixed chop, fixed bl8, or the command's own choice
        cmd_bc4 = (mode_q.burst == BURST_BC4) ||
                  ((mode_q.burst == BURST_OTF) && cmd.bc4);
        wr_arrive = dyn && wr_hist[tap(dodt, 0)];
        rd_arrive = rd_hist[tap(roff, 0)];
        // the chop choice travels with the command, so a later mode write cannot bend it
        wlen = wr_len(wbc4_hist[tap(dodt, 0)], mode_q.pre2, mode_q.crc);
        if (rbc4_hist[tap(roff, 0)]) begin
            rlen = mode_q.pre2 ? RD_ON4_2T : RD_ON4_1T;
        end else begin
            rlen = mode_q.pre2 ? RD_ON8_2T : RD_ON8_1T;
        end
    end

    // ==========================================================
    // next state of the termination pipeline
    always_comb begin
        // histories shift one place per clock, newest at bit 0
        // a deeper history costs only flops; the tap picks the age that is due
        next_odt_hist  = {odt_hist[MAX_LAT-2:0], odt_s2};
        next_wr_hist   = {wr_hist[MAX_LAT-2:0], cmd.wr};
        next_wbc4_hist = {wbc4_hist[MAX_LAT-2:0], cmd_bc4};
        next_rd_hist   = {rd_hist[MAX_LAT-2:0], cmd.rd};
        next_rbc4_hist = {rbc4_hist[MAX_LAT-2:0], cmd_bc4};
        // latency path only with a locked dll, in every power state alike;
        // without it the pin is followed straight after the synchroniser
        // odt_s1 makes the sampling edge; the two sync stages before bit 0
        // of the history are the lag taken off the tap, keeping on and off
        // exactly dodt clocks after that edge
        if (mode_q.dll_locked) begin
            next_nom = odt_hist[tap(dodt, SYNC_LAG)];
        end else begin
            next_nom = odt_s2;
        end
        // a new write restarts the window, so overlapping writes extend it
        // the count reaches zero on the edge that hands back to the odt level
        if (wr_arrive) begin
            next_wrc = wlen;
        end else if (wrc != 4'h0) begin
            next_wrc = wrc - 4'h1;
        end else begin
            next_wrc = 4'h0;
        end
        // quiet window while the read burst is driven
        if (rd_arrive) begin
            next_rdc = rlen;
        end else if (rdc != 4'h0) begin
            next_rdc = rdc - 4'h1;
        end else begin
            next_rdc = 4'h0;
        end
        // driving beats everything, write beats odt level
        if (next_rdc != 4'h0) begin
            next_sel   = SEL_OFF;
            next_value = 3'b000;
        end else if (next_wrc != 4'h0) begin
            next_sel   = SEL_WR;
            next_value = {1'b0, rtt_q.wr};
        end else if (next_nom) begin
            next_sel   = SEL_NOM;
            next_value = rtt_q.nom;
        end else begin
            next_sel   = SEL_PARK;
            next_value = rtt_q.park;
        end
    end

    // ==========================================================
    // register port decode, reads answer one clock later
    // settings take effect on the next edge, also for windows in flight
    always_comb begin
        next_lat   = lat_q;
        next_mode  = mode_q;
        next_rtt   = rtt_q;
        next_rdata = 32'h0000_0000;                        // unmapped reads zero
        if (reg_we) begin
            if (reg_addr == REG_LATENCY) begin
                next_lat = reg_wdata & LAT_MASK;
            end else if (reg_addr == REG_MODE) begin
                next_mode = reg_wdata & MODE_MASK;
            end else if (reg_addr == REG_RTT) begin
                next_rtt = reg_wdata & RTT_MASK;
            end
        end
        if (reg_re) begin
            if (reg_addr == REG_LATENCY) begin
                next_rdata = lat_q;
            end else if (reg_addr == REG_MODE) begin
                next_rdata = mode_q;
            end else if (reg_addr == REG_RTT) begin
                next_rdata = rtt_q;
            end else if (reg_addr == REG_STATUS) begin
                next_rdata = {22'h0, rdc != 4'h0, wrc != 4'h0, 3'h0, nom_q, 2'h0, rtt_sel};
            end
        end
    end

    // ==========================================================
    // state registers, frozen while ce is low
    // the synchroniser freezes too, so a held block resumes with its
    // pipeline and pin history intact
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            lat_q     <= LAT_RST;
            mode_q    <= MODE_RST;
            rtt_q     <= RTT_RST;
            odt_s1    <= 1'b0;
            odt_s2    <= 1'b0;
            odt_hist  <= '0;
            wr_hist   <= '0;
            wbc4_hist <= '0;
            rd_hist   <= '0;
            rbc4_hist <= '0;
            wrc       <= 4'h0;
            rdc       <= 4'h0;
            nom_q     <= 1'b0;
            rtt_sel   <= SEL_PARK;
            rtt_value <= 3'b000;
            reg_rdata <= 32'h0000_0000;
        end else if (ce) begin
            lat_q     <= next_lat;
            mode_q    <= next_mode;
            rtt_q     <= next_rtt;
            odt_s1    <= odt_pin;
            odt_s2    <= odt_s1;
            odt_hist  <= next_odt_hist;
            wr_hist   <= next_wr_hist;
            wbc4_hist <= next_wbc4_hist;
            rd_hist   <= next_rd_hist;
            rbc4_hist <= next_rbc4_hist;
            wrc       <= next_wrc;
            rdc       <= next_rdc;
            nom_q     <= next_nom;
            rtt_sel   <= next_sel;
            rtt_value <= next_value;
            reg_rdata <= next_rdata;
        end
    end

    // ==========================================================
    // checks
    chk_read_quiet: assert property (@(posedge core_clk) disable iff (sys_rst)
        (rdc != 4'h0) |-> (rtt_sel == SEL_OFF && rtt_value == 3'b000))
        else $error("termination on during read drive");
    chk_write_override: assert property (@(posedge core_clk) disable iff (sys_rst)
        (rdc == 4'h0 && wrc != 4'h0) |-> rtt_sel == SEL_WR)
        else $error("write termination not selected");
    chk_park_low: assert property (@(posedge core_clk) disable iff (sys_rst)
        (rdc == 4'h0 && wrc == 4'h0) |-> (rtt_sel == (nom_q ? SEL_NOM : SEL_PARK)))
        else $error("odt level not followed");
    chk_wr_start: assert property (@(posedge core_clk) disable iff (sys_rst)
        (ce && wr_arrive) |=> (wrc == $past(wlen) && rtt_sel != SEL_PARK))
        else $error("write window did not start");
    chk_rd_start: assert property (@(posedge core_clk) disable iff (sys_rst)
        (ce && rd_arrive) |=> (rdc == $past(rlen) && rdc >= 4'h4))
        else $error("read quiet window did not start");
    chk_dyn_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
        (ce && !dyn && wrc == 4'h0) |=> wrc == 4'h0)
        else $error("write termination without dynamic mode");
    chk_wr_countdown: assert property (@(posedge core_clk) disable iff (sys_rst)
        (ce && !wr_arrive && wrc != 4'h0) |=> wrc == $past(wrc) - 4'h1)
        else $error("write window length wrong");
    // the read quiet window counts down one per clock and then lets go
    chk_rd_countdown: assert property (@(posedge core_clk) disable iff (sys_rst)
        (ce && !rd_arrive && rdc != 4'h0) |=> rdc == $past(rdc) - 4'h1)
        else $error("read quiet length wrong");
    chk_rd_release: assert property (@(posedge core_clk) disable iff (sys_rst)
        (ce && !rd_arrive && rdc == 4'h1) |=> rtt_sel != SEL_OFF)
        else $error("termination not back after read");
    chk_nom_code: assert property (@(posedge core_clk) disable iff (sys_rst)
        ($past(ce) && rtt_sel == SEL_NOM) |-> rtt_value == $past(rtt_q.nom))
        else $error("nominal code mismatch");
endmodule : odt_ctrl

// File: design/odt_pkg.sv
/*
 * shared constants, register layouts and carrier types of the termination control.
 * assumes one core clock and a plain register port with word addresses.
 */
package odt_pkg;
    // ==========================================================
    // register word addresses
    localparam logic [3:0]  REG_LATENCY = 4'h0;           // cl, cwl, al, pl
    localparam logic [3:0]  REG_MODE    = 4'h1;           // preamble, crc, burst, dll
    localparam logic [3:0]  REG_RTT     = 4'h2;           // nom, park, wr codes
    localparam logic [3:0]  REG_STATUS  = 4'h3;           // live selection, read only
    // writable bits of each word, reserved bits read as zero
    localparam logic [31:0] LAT_MASK    = 32'h0F3F_3F3F;
    localparam logic [31:0] MODE_MASK   = 32'h0000_001F;
    localparam logic [31:0] RTT_MASK    = 32'h0000_0377;
    // reset values: cl 11, cwl 9, no al or pl, dll locked, 1tck, bl8
    localparam logic [31:0] LAT_RST     = 32'h0000_090B;
    localparam logic [31:0] MODE_RST    = 32'h0000_0010;
    localparam logic [31:0] RTT_RST     = 32'h0000_0000;
    // ==========================================================
    // field layouts, lsb last
    typedef struct packed {
        logic [3:0] rsv3;  logic [3:0] pl;
        logic [1:0] rsv2;  logic [5:0] al;
        logic [1:0] rsv1;  logic [5:0] cwl;
        logic [1:0] rsv0;  logic [5:0] cl;
    } lat_reg_t;
    typedef struct packed {
        logic [26:0] rsv;
        logic        dll_locked;                           // dll on and locked
        logic [1:0]  burst;                                // burst mode choice
        logic        crc;                                  // write crc enabled
        logic        pre2;                                 // 2tck preamble
    } mode_reg_t;
    typedef struct packed {
        logic [21:0] rsv2; logic [1:0] wr;
        logic        rsv1; logic [2:0] park;
        logic        rsv0; logic [2:0] nom;
    } rtt_reg_t;
    // ==========================================================
    // burst modes
    localparam logic [1:0]  BURST_BL8   = 2'b00;
    localparam logic [1:0]  BURST_OTF   = 2'b01;
    localparam logic [1:0]  BURST_BC4   = 2'b10;
    // termination selection
    typedef enum logic [1:0] {
        SEL_PARK = 2'b00, SEL_NOM = 2'b01, SEL_WR = 2'b10, SEL_OFF = 2'b11
    } rtt_sel_t;
    // command carrier from the command decoder
    typedef struct packed {
        logic wr;                                          // any write variant
        logic rd;                                          // any read variant
        logic bc4;                                         // on the fly chop choice
    } dram_cmd_t;
    // ==========================================================
    // timing counts in clocks
    localparam logic [6:0]  TRIM_1TCK   = 7'h02;           // latency trim, 1tck
    localparam logic [6:0]  TRIM_2TCK   = 7'h03;           // latency trim, 2tck
    localparam logic [3:0]  RD_ON4_1T   = 4'h4;
    localparam logic [3:0]  RD_ON4_2T   = 4'h5;
    localparam logic [3:0]  RD_ON8_1T   = 4'h6;
    localparam logic [3:0]  RD_ON8_2T   = 4'h7;
    localparam logic [3:0]  WR4_1T      = 4'h4;
    localparam logic [3:0]  WR4_1T_CRC  = 4'h7;
    localparam logic [3:0]  WR4_2T      = 4'h5;
    localparam logic [3:0]  WR4_2T_CRC  = 4'h8;
    localparam logic [3:0]  WR8_1T      = 4'h6;
    localparam logic [3:0]  WR8_1T_CRC  = 4'h7;
    localparam logic [3:0]  WR8_2T      = 4'h7;
    localparam logic [3:0]  WR8_2T_CRC  = 4'h8;
    localparam int          SYNC_LAG    = 2;               // pin to history lag, two sync flops
endpackage : odt_pkg

// File: bench/odt_host_model.sv
/*
 * controller-side model: drives the odt pin and one-cycle command pulses.
 * assumes the core clock is shared with the termination block.
 */
`timescale 1ns/1ns
module odt_host_model #(
    parameter int ODTH_MIN = 6                 // minimum odt high hold, plain default
) (
    input  wire logic               core_clk,
    input  wire logic               sys_rst,
    output      logic               odt_pin,
    output      odt_pkg::dram_cmd_t cmd
);
    import odt_pkg::*;
    // ==========================================================
    // edge counter shared with the bench, and hold counter
    int cyc  = 0;                              // edges seen since time zero
    int held = 0;                              // clocks since odt high or a write

    initial begin
        odt_pin = 1'b0;
        cmd     = '0;
    end

    // the hold counts from the write or from odt first registered high
    always @(posedge core_clk) begin
        cyc  <= cyc + 1;
        held <= sys_rst ? 0 : (cmd.wr ? 1 : (odt_pin ? held + 1 : 0));
    end

    // ==========================================================
    // one command pulse; s is the edge that registers it
    task automatic issue(input dram_cmd_t c, output int s);
        @(posedge core_clk);
        cmd <= c;
        s = cyc + 2;
        @(posedge core_clk);
        cmd <= '0;
    endtask : issue

    // odt level change; lowering waits until the minimum hold is met
    task automatic drive_odt(input logic v, output int s);
        @(posedge core_clk);
        while (!v && odt_pin && held < ODTH_MIN) @(posedge core_clk);
        odt_pin <= v;
        s = cyc + 2;
    endtask : drive_odt
endmodule : odt_host_model

// File: bench/odt_ctrl_test.sv
/*
 * self-checking bench of the termination control: registers, odt, writes, reads.
 * assumes the host model drives pin and commands; dll stays locked throughout.
 */
`timescale 1ns/1ns
module odt_ctrl_test;
    import odt_pkg::*;
    typedef struct { int c; logic [31:0] v; } note_t;
    // ==========================================================
    // stimulus and observation signals
    logic        core_clk  = 1'b0;
    logic        sys_rst   = 1'b1;
    logic        ce        = 1'b1;             // frozen once near the end
    logic        odt_pin;
    dram_cmd_t   cmd;
    logic [3:0]  reg_addr  = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_we    = 1'b0;
    logic        reg_re    = 1'b0;
    logic [31:0] reg_rdata;
    rtt_sel_t    rtt_sel, b, pb;
    logic [2:0]  rtt_value, nom, park;
    logic [1:0]  wrc;
    logic [15:0] rnd       = 16'h94C2;         // lfsr seed
    logic [31:0] d, md;
    logic        pre2, crc, eb, o, po;
    int          errors = 0, n_checks = 0, cl, al, pl, lw, lr, s, n;
    int          w4[4] = '{4, 7, 5, 8};        // chop4 write span by pre2, crc
    int          w8[4] = '{6, 7, 7, 8};        // bl8 write span by pre2, crc
    note_t       rq[$], tq[$];                 // pending read and termination notes

    always #5 core_clk = ~core_clk;

    odt_ctrl odt_ctrl_i (.core_clk(core_clk), .sys_rst(sys_rst), .ce(ce),
        .odt_pin(odt_pin), .cmd(cmd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
        .rtt_sel(rtt_sel), .rtt_value(rtt_value));
    odt_host_model odt_host_model_i (.core_clk(core_clk), .sys_rst(sys_rst),
        .odt_pin(odt_pin), .cmd(cmd));

    // ==========================================================
    // helpers
    function automatic logic [15:0] step(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : step

    // expected selection plus the code the selected value carries
    function automatic logic [31:0] ev(input rtt_sel_t sl);
        return {27'h0, sl, sl == SEL_NOM ? nom : sl == SEL_PARK ? park :
                sl == SEL_WR ? {1'b0, wrc} : 3'h0};
    endfunction : ev

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic note(input int c, input rtt_sel_t sl);
        tq.push_back('{c, ev(sl)});
    endtask : note

    task automatic upto(input int c);
        while (odt_host_model_i.cyc < c) @(posedge core_clk);
    endtask : upto

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge core_clk);
        reg_we    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_we    <= 1'b0;
    endtask : reg_wr

    // read data are due only in the cycle after the strobe
    task automatic reg_rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge core_clk);
        reg_re   <= 1'b1;
        reg_addr <= a;
        rq.push_back('{odt_host_model_i.cyc + 2, e});
        @(posedge core_clk);
        reg_re   <= 1'b0;
    endtask : reg_rd

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish

    // ==========================================================
    // watcher: compares each note in the cycle it falls due
    always @(posedge core_clk) begin
        while (rq.size() > 0 && rq[0].c <= odt_host_model_i.cyc) begin
            check(reg_rdata, rq[0].v);
            void'(rq.pop_front());
        end
        while (tq.size() > 0 && tq[0].c <= odt_host_model_i.cyc) begin
            check({27'h0, rtt_sel, rtt_value}, tq[0].v);
            void'(tq.pop_front());
        end
    end

    // ==========================================================
    // main sequence; dll stays locked so wr bits never need clearing
    initial begin
        po = 1'b0;
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        reg_rd(REG_LATENCY, LAT_RST);
        reg_rd(REG_MODE, MODE_RST);
        reg_rd(REG_RTT, RTT_RST);
        reg_wr(4'h9, 32'hFFFF_FFFF);
        reg_rd(4'h9, 32'h0000_0000);
        for (int i = 0; i < 12; i++) begin
            rnd  = step(rnd);
            pre2 = i[0];
            crc  = i[1];
            o    = rnd[0];
            cl   = 10 + rnd[2:1];
            al   = rnd[4:3];
            pl   = rnd[6:5];
            reg_wr(REG_LATENCY, {4'h0, 4'(pl), 2'h0, 6'(al), 2'h0, 6'(9), 2'h0, 6'(cl)});
            md = {27'h0, 1'b1, 2'(i / 4), crc, pre2};
            reg_wr(REG_MODE, md | 32'hFFFF_FFE0);
            reg_rd(REG_MODE, md);
            d = {rnd, step(rnd)};
            if (i == 5) d[9:8] = 2'h0;         // one pass with dynamic switching off
            reg_wr(REG_RTT, d);
            reg_rd(REG_RTT, d & RTT_MASK);
            nom  = d[2:0];
            park = d[6:4];
            wrc  = d[9:8];
            lw = 9 + al + pl - 2 - pre2;
            lr = cl + al + pl - 2 - pre2;
            // odt level change shows after the direct latency
            pb = po ? SEL_NOM : SEL_PARK;
            b  = o ? SEL_NOM : SEL_PARK;
            odt_host_model_i.drive_odt(o, s);
            note(s + lw - 1, pb);
            note(s + lw, b);
            upto(s + lw + 2);
            // write: wr window, then back to what odt selects
            eb = (i / 4 == 2) || (i / 4 == 1 && rnd[7]);
            n  = eb ? w4[2 * pre2 + crc] : w8[2 * pre2 + crc];
            odt_host_model_i.issue('{wr: 1'b1, rd: 1'b0, bc4: rnd[7]}, s);
            if (wrc != 2'h0) begin
                note(s + lw - 1, b);
                note(s + lw, SEL_WR);
                note(s + lw + n - 1, SEL_WR);
                note(s + lw + n, b);
            end else begin
                note(s + lw, b);
                note(s + lw + n, b);
            end
            upto(s + lw + n + 2);
            // read: off while driving, park or nominal afterwards
            n = lr + (eb ? 4 : 6) + pre2;
            odt_host_model_i.issue('{wr: 1'b0, rd: 1'b1, bc4: rnd[7]}, s);
            note(s + lr - 1, b);
            note(s + lr, SEL_OFF);
            note(s + n - 1, SEL_OFF);
            note(s + n, b);
            upto(s + n + 2);
            // status snapshot once all windows have closed
            reg_rd(REG_STATUS, {27'h0, o, 2'h0, b});
            po = o;
        end
        // frozen clock enable: a write must leave no trace
        @(posedge core_clk);
        ce <= 1'b0;
        reg_wr(REG_RTT, ~d);
        ce <= 1'b1;
        reg_rd(REG_RTT, d & RTT_MASK);
        upto(odt_host_model_i.cyc + 3);
        tally_and_finish;
    end

    // watchdog, well beyond the thousand or so cycles the run needs
    initial begin
        #200000;
        errors++;
        tally_and_finish;
    end
endmodule : odt_ctrl_test
